/* verilog/swc_pkg.sv */
// constants, types and register map of the sleep and wake controller
package swc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_INTCTL = 3'h0;
  localparam logic [2:0] OFS_PENA = 3'h1;
  localparam logic [2:0] OFS_PENB = 3'h2;
  localparam logic [2:0] OFS_PREQA = 3'h3;
  localparam logic [2:0] OFS_PREQB = 3'h4;
  localparam logic [2:0] OFS_CSTAT = 3'h5;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int CONV2_BIT = 6;
  localparam int BCOL_BIT = 3;
  localparam int EXPIRY_BIT = 4;
  localparam int PDOWN_BIT = 3;

  // ---------------------------------------------------------------
  // implemented-bit masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_PA = 8'hfb;
  localparam logic [7:0] MASK_PB = 8'h48;
  localparam logic [7:0] MASK_ALU = 8'h07;
  localparam logic [7:0] RST_INTCTL = 8'h00;
  localparam logic [7:0] RST_PENA = 8'h00;
  localparam logic [7:0] RST_PENB = 8'h00;
  localparam logic [7:0] RST_PREQA = 8'h00;
  localparam logic [7:0] RST_PREQB = 8'h00;
  localparam logic [2:0] RST_ALU = 3'h0;

  // ---------------------------------------------------------------
  // watchdog: low-frequency ticks, 2 s nominal at 31 kHz
  // ---------------------------------------------------------------
  localparam logic [15:0] WDT_DEF_TICKS = 16'hf230;
  localparam logic [1:0] WDT_ALWAYS = 2'h3;
  localparam logic [1:0] WDT_NO_SLEEP = 2'h2;
  localparam logic [1:0] WDT_SOFT = 2'h1;

  // ---------------------------------------------------------------
  // timer clock sources
  // ---------------------------------------------------------------
  localparam logic [1:0] T1_SRC_SYS = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_RESUME = 3'b100
  } swc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } swc_req_t;

  typedef struct packed {
    logic [2:0] core;
    logic [7:0] pa;
    logic [7:0] pb;
  } swc_evt_t;

endpackage : swc_pkg

/* verilog/swc_wdt.sv */
// watchdog counter running on low-frequency ticks
`timescale 1ns/10ps
module swc_wdt
  import swc_pkg::*;
#(
  parameter logic [15:0] LIMIT = WDT_DEF_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  // status
  output logic [15:0] count,
  output logic expired
);

  logic [15:0] cnt_ff;
  logic exp_ff;
  logic [15:0] nxt_cnt;
  logic nxt_exp;
  wire at_limit = (cnt_ff == LIMIT);

  // a stopped watchdog stays cleared
  assign nxt_cnt = (clear || !run || at_limit) ? 16'h0000 :
                   tick ? cnt_ff + 16'h0001 : cnt_ff;
  assign nxt_exp = run && !clear && at_limit;
  assign count = cnt_ff;
  assign expired = exp_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

endmodule : swc_wdt

/* verilog/swc_top.sv */
// sleep and wake controller with interrupt request and enable registers
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
module swc_top
  import swc_pkg::*;
#(
  parameter logic [15:0] WDT_TIMEOUT_TICKS = WDT_DEF_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire swc_req_t req,
  output logic [7:0] rd_data_ff,
  // cpu sequencer
  input wire logic sleep_instr,
  input wire logic clr_wdt_instr,
  input wire logic next_instr_done,
  output logic cpu_clk_en_ff,
  output logic prefetch_ff,
  output logic nop_ff,
  output logic wake_ff,
  output logic vector_ff,
  output logic irq_req_ff,
  // interrupt and reset sources
  input wire swc_evt_t evt,
  input wire logic master_reset_pin_evt,
  input wire logic master_reset_pin_en,
  input wire logic brownout_reset_evt,
  input wire logic brownout_reset_en,
  input wire logic power_on_evt,
  output logic dev_reset_ff,
  output logic wdt_reset_ff,
  // low-frequency clock and sleep-time peripherals
  input wire logic lf_tick,
  input wire logic [1:0] wdt_mode,
  input wire logic wdt_soft_en,
  input wire logic [1:0] timer_src,
  input wire logic conv_rc_sel,
  output logic lf_osc_run_ff,
  output logic timer_run_ff,
  output logic conv_run_ff,
  output logic port_hold_ff
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  swc_state_t state_ff;
  swc_state_t nxt_state;
  logic [7:0] intctl_ff;
  logic [7:0] pena_ff;
  logic [7:0] penb_ff;
  logic [7:0] preqa_ff;
  logic [7:0] preqb_ff;
  logic [2:0] alu_ff;
  logic expiry_ff;
  logic pdown_ff;
  logic [15:0] wdt_count;
  logic wdt_expired;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr_intctl = req.wr && (req.addr == OFS_INTCTL);
  wire wr_pena = req.wr && (req.addr == OFS_PENA);
  wire wr_penb = req.wr && (req.addr == OFS_PENB);
  wire wr_preqa = req.wr && (req.addr == OFS_PREQA);
  wire wr_preqb = req.wr && (req.addr == OFS_PREQB);
  wire wr_cstat = req.wr && (req.addr == OFS_CSTAT);
  wire in_run = (state_ff == ST_RUN);
  wire in_sleep = (state_ff == ST_SLEEP);
  wire in_resume = (state_ff == ST_RESUME);
  wire global_irq_enable = intctl_ff[GIE_BIT];
  wire peripheral_irq_enable = intctl_ff[PERIPHERAL_IRQ_ENABLE_BIT];

  // ---------------------------------------------------------------
  // wake request
  // ---------------------------------------------------------------
  wire core_hit = |(intctl_ff[5:3] & intctl_ff[2:0]);
  wire periph_hit = peripheral_irq_enable && (|(pena_ff & preqa_ff) || |(penb_ff & preqb_ff));
  wire wake_req = core_hit || periph_hit;
  wire lf_wake = in_sleep && lf_tick && wake_req;
  wire wdt_wake = in_sleep && wdt_expired;
  wire any_wake = lf_wake || wdt_wake;
  // reset sources act the same asleep or awake
  wire reset_evt = (master_reset_pin_evt && master_reset_pin_en) ||
                   (brownout_reset_evt && brownout_reset_en) ||
                   power_on_evt;
  wire sleep_go = in_run && sleep_instr && !reset_evt;
  wire sleep_nop = sleep_go && wake_req;
  wire sleep_enter = sleep_go && !wake_req;

  // ---------------------------------------------------------------
  // flags: hardware set wins over software write
  // ---------------------------------------------------------------
  wire [7:0] nxt_intctl = (wr_intctl ? req.wdata : intctl_ff) |
                          {5'h00, evt.core};
  wire [7:0] nxt_pena = (wr_pena ? req.wdata : pena_ff) & MASK_PA;
  wire [7:0] nxt_penb = (wr_penb ? req.wdata : penb_ff) & MASK_PB;
  wire [7:0] nxt_preqa = ((wr_preqa ? req.wdata : preqa_ff) | evt.pa) & MASK_PA;
  wire [7:0] nxt_preqb = ((wr_preqb ? req.wdata : preqb_ff) | evt.pb) & MASK_PB;
  wire [2:0] nxt_alu = wr_cstat ? req.wdata[2:0] : alu_ff;

  // sleep entry and watchdog wake override software; a no-op leaves both alone
  wire nxt_expiry = sleep_enter ? 1'b1 :
                    wdt_wake ? 1'b0 :
                    clr_wdt_instr ? 1'b1 : expiry_ff;
  wire nxt_pdown = sleep_enter ? 1'b0 :
                   clr_wdt_instr ? 1'b1 : pdown_ff;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0] cstat_val = {3'h0, expiry_ff, pdown_ff, alu_ff};
  wire [7:0] rd_mux = (req.addr == OFS_INTCTL) ? intctl_ff :
                      (req.addr == OFS_PENA) ? pena_ff :
                      (req.addr == OFS_PENB) ? penb_ff :
                      (req.addr == OFS_PREQA) ? preqa_ff :
                      (req.addr == OFS_PREQB) ? (preqb_ff & MASK_PB) :
                      (req.addr == OFS_CSTAT) ? cstat_val : 8'h00;
  wire [7:0] nxt_rd_data = req.rd ? rd_mux : 8'h00;

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  wire wdt_run = (wdt_mode == WDT_ALWAYS) ||
                 ((wdt_mode == WDT_NO_SLEEP) && !in_sleep) ||
                 ((wdt_mode == WDT_SOFT) && wdt_soft_en);
  wire wdt_clear = sleep_enter || any_wake || clr_wdt_instr;

  swc_wdt #(
    .LIMIT(WDT_TIMEOUT_TICKS)
  ) u_wdt (
    .clk(clk),
    .rst_n(rst_n),
    .clear(wdt_clear),
    .run(wdt_run),
    .tick(lf_tick),
    .count(wdt_count),
    .expired(wdt_expired)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (sleep_enter) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_wake) begin
          nxt_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (next_instr_done) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
    if (reset_evt) begin
      nxt_state = ST_RUN;
    end
  end

  wire nxt_asleep = (nxt_state == ST_SLEEP);
  wire nxt_vector = in_resume && next_instr_done && global_irq_enable && wake_req;
  wire nxt_timer_run = !nxt_asleep || (timer_src != T1_SRC_SYS);
  wire nxt_conv_run = !nxt_asleep || conv_rc_sel;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
      intctl_ff <= RST_INTCTL;
      pena_ff <= RST_PENA;
      penb_ff <= RST_PENB;
      preqa_ff <= RST_PREQA;
      preqb_ff <= RST_PREQB;
      alu_ff <= RST_ALU;
      expiry_ff <= 1'b1;
      pdown_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      intctl_ff <= nxt_intctl;
      pena_ff <= nxt_pena;
      penb_ff <= nxt_penb;
      preqa_ff <= nxt_preqa;
      preqb_ff <= nxt_preqb;
      alu_ff <= nxt_alu;
      expiry_ff <= nxt_expiry;
      pdown_ff <= nxt_pdown;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
      cpu_clk_en_ff <= 1'b1;
      prefetch_ff <= 1'b0;
      nop_ff <= 1'b0;
      wake_ff <= 1'b0;
      vector_ff <= 1'b0;
      irq_req_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      cpu_clk_en_ff <= !nxt_asleep;
      prefetch_ff <= sleep_go;
      nop_ff <= sleep_nop;
      wake_ff <= any_wake && !reset_evt;
      vector_ff <= nxt_vector;
      irq_req_ff <= global_irq_enable && in_run && wake_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dev_reset_ff <= 1'b0;
      wdt_reset_ff <= 1'b0;
      lf_osc_run_ff <= 1'b0;
      timer_run_ff <= 1'b1;
      conv_run_ff <= 1'b1;
      port_hold_ff <= 1'b0;
    end else begin
      dev_reset_ff <= reset_evt;
      wdt_reset_ff <= wdt_expired && !in_sleep;
      lf_osc_run_ff <= 1'b1;
      timer_run_ff <= nxt_timer_run;
      conv_run_ff <= nxt_conv_run;
      port_hold_ff <= nxt_asleep;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_flag_set;
    evt.pb[CONV2_BIT] |=> preqb_ff[CONV2_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("request flag lost its event");

  property p_preqb_read;
    req.rd && (req.addr == OFS_PREQB) |=> (rd_data_ff & ~MASK_PB) == 8'h00;
  endproperty
  a_preqb_read: assert property (p_preqb_read) else $error("unused request bit read one");

  property p_entry_cause;
    $rose(port_hold_ff) |-> $past(sleep_instr) && $past(in_run);
  endproperty
  a_entry_cause: assert property (p_entry_cause) else $error("sleep without instruction");

  property p_entry_flags;
    sleep_enter |=> !pdown_ff && expiry_ff && !cpu_clk_en_ff && (wdt_count == 16'h0000);
  endproperty
  a_entry_flags: assert property (p_entry_flags) else $error("bad state after sleep entry");

  property p_clk_stop;
    in_sleep |-> !cpu_clk_en_ff && port_hold_ff;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("cpu clock runs asleep");

  property p_nop;
    sleep_nop && !clr_wdt_instr |=> nop_ff && in_run && (pdown_ff == $past(pdown_ff)) &&
      (expiry_ff == $past(expiry_ff));
  endproperty
  a_nop: assert property (p_nop) else $error("no-op power-down changed state");

  property p_wake_clear;
    any_wake && !reset_evt |=> wake_ff[*1] ##0 (wdt_count == 16'h0000) ##1 cpu_clk_en_ff;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake left watchdog running");

  property p_reset_wake;
    in_sleep && power_on_evt |=> dev_reset_ff && in_run && cpu_clk_en_ff && !wake_ff;
  endproperty
  a_reset_wake: assert property (p_reset_wake) else $error("reset wake did not reset");

  property p_vector;
    in_resume && next_instr_done && !reset_evt |=> vector_ff == $past(global_irq_enable && wake_req);
  endproperty
  a_vector: assert property (p_vector) else $error("vector after wake wrong");

  property p_prefetch;
    sleep_go |=> prefetch_ff ##1 !prefetch_ff;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch not one cycle");

  property p_wdt_wake;
    wdt_wake && !reset_evt |=> !expiry_ff && wake_ff && !wdt_reset_ff;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake mishandled");

  property p_wdt_sleep_off;
    in_sleep && (wdt_mode == WDT_NO_SLEEP) |=> (wdt_count == 16'h0000);
  endproperty
  a_wdt_sleep_off: assert property (p_wdt_sleep_off) else $error("watchdog counts asleep");

  property p_irq_wake;
    lf_wake && !reset_evt |=> wake_ff && in_resume && cpu_clk_en_ff && !port_hold_ff;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake did not resume");

  c_enter: cover property (sleep_enter ##[1:200] in_sleep);
  c_irq_wake: cover property (lf_wake ##1 wake_ff ##[1:20] vector_ff);
  c_nop: cover property (sleep_nop);
  c_wdt_wake: cover property (wdt_wake);
  c_reset_wake: cover property (in_sleep && reset_evt);

endmodule : swc_top

/* testbench/swc_cpu_model.sv */
// cpu core and low-frequency oscillator model facing the controller
`timescale 1ns/10ps
module swc_cpu_model #(
  parameter int LF_DIV = 4
) (
  // clock
  input wire logic clk,
  // control from the bench
  input wire logic slow,
  // from the controller
  input wire logic wake,
  // to the controller
  output logic lf_tick,
  output logic next_instr_done
);
  int div_cnt = 0;
  int run_cnt = 0;

  always @(posedge clk) begin
    div_cnt <= (div_cnt == LF_DIV - 1) ? 0 : div_cnt + 1;
    lf_tick <= (div_cnt == LF_DIV - 1);
    // the instruction after power-down is a no-op, so a late finish is harmless
    next_instr_done <= (run_cnt == 1);
    if (wake) begin
      run_cnt <= slow ? 6 : 1;
    end else if (run_cnt > 0) begin
      run_cnt <= run_cnt - 1;
    end
  end
endmodule : swc_cpu_model

/* testbench/sleep_wake_controller_tb.sv */
// self-checking bench for the sleep and wake controller
`timescale 1ns/10ps
module sleep_wake_controller_tb;
  import swc_pkg::*;
  logic clk, rst_n, sleep_instr, next_instr_done, lf_tick, slow, clr_wdt, soft_en;
  logic cpu_clk_en_ff, prefetch_ff, nop_ff, wake_ff, vector_ff, irq_req_ff;
  logic mrp_evt, mrp_en, bor_evt, bor_en, por_evt, dev_reset_ff, wdt_reset_ff;
  logic conv_rc_sel, lf_osc_run_ff, timer_run_ff, conv_run_ff, port_hold_ff;
  logic [1:0] wdt_mode;
  logic [1:0] timer_src;
  logic [7:0] rd_data_ff;
  logic [7:0] d;
  logic [31:0] lfsr;
  swc_req_t req;
  swc_evt_t evt;
  swc_evt_t ev;
  int n_errors;
  int checks_done;

  swc_top #(.WDT_TIMEOUT_TICKS(16'h0008)) dut (
    .clk(clk), .rst_n(rst_n), .req(req), .rd_data_ff(rd_data_ff),
    .sleep_instr(sleep_instr), .clr_wdt_instr(clr_wdt), .next_instr_done(next_instr_done),
    .cpu_clk_en_ff(cpu_clk_en_ff), .prefetch_ff(prefetch_ff), .nop_ff(nop_ff),
    .wake_ff(wake_ff), .vector_ff(vector_ff), .irq_req_ff(irq_req_ff), .evt(evt),
    .master_reset_pin_evt(mrp_evt), .master_reset_pin_en(mrp_en),
    .brownout_reset_evt(bor_evt), .brownout_reset_en(bor_en), .power_on_evt(por_evt),
    .dev_reset_ff(dev_reset_ff), .wdt_reset_ff(wdt_reset_ff), .lf_tick(lf_tick),
    .wdt_mode(wdt_mode), .wdt_soft_en(soft_en), .timer_src(timer_src),
    .conv_rc_sel(conv_rc_sel), .lf_osc_run_ff(lf_osc_run_ff),
    .timer_run_ff(timer_run_ff), .conv_run_ff(conv_run_ff), .port_hold_ff(port_hold_ff)
  );

  swc_cpu_model #(.LF_DIV(4)) cpu (
    .clk(clk), .slow(slow), .wake(wake_ff), .lf_tick(lf_tick),
    .next_instr_done(next_instr_done)
  );

  // ---------------------------------------------------------------
  // expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [7:0] exp_reg(input logic [2:0] a, input logic [7:0] v);
    case (a)
      OFS_INTCTL: return v;
      OFS_PENA, OFS_PREQA: return v & MASK_PA;
      OFS_PENB, OFS_PREQB: return v & MASK_PB;
      OFS_CSTAT: return (v & MASK_ALU) | 8'h18;
      default: return 8'h00;
    endcase
  endfunction : exp_reg

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    v = rd_data_ff;
  endtask : rd

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic do_sleep(input logic noop, input swc_evt_t e);
    sleep_instr <= 1'b1;
    evt <= e;
    @(posedge clk);
    sleep_instr <= 1'b0;
    evt <= '0;
    @(posedge clk);
    chk({7'h0, prefetch_ff}, 8'h01);
    chk({7'h0, nop_ff}, {7'h0, noop});
    chk({7'h0, cpu_clk_en_ff}, {7'h0, noop});
    chk({7'h0, port_hold_ff}, {7'h0, ~noop});
  endtask : do_sleep

  task automatic wait_wake(input int lim);
    int k;
    k = 0;
    while (wake_ff !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk({7'h0, wake_ff}, 8'h01);
    chk({7'h0, cpu_clk_en_ff}, 8'h01);
  endtask : wait_wake

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    evt = '0;
    ev = '0;
    {sleep_instr, mrp_evt, mrp_en, bor_evt, bor_en, por_evt, conv_rc_sel, slow} = 8'h00;
    {clr_wdt, soft_en} = 2'h0;
    wdt_mode = 2'h0;
    timer_src = 2'h0;
    lfsr = 32'h87d43e7e;
    n_errors = 0;
    checks_done = 0;
    do_reset();
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      chk(d, (a == 5) ? 8'h18 : 8'h00);
    end
    repeat (24) begin
      lfsr = lfsr_next(lfsr);
      wr(lfsr[2:0], lfsr[15:8]);
      rd(lfsr[2:0], d);
      chk(d, exp_reg(lfsr[2:0], lfsr[15:8]));
    end
    $display("test registers done");
    do_reset();
    lfsr = lfsr_next(lfsr);
    evt <= '{core: 3'h0, pa: lfsr[7:0], pb: 8'hff};
    @(posedge clk);
    evt <= '0;
    rd(OFS_PREQA, d);
    chk(d, lfsr[7:0] & MASK_PA);
    rd(OFS_PREQB, d);
    chk(d, 8'h48);
    wr(OFS_PENB, 8'h40);
    wr(OFS_INTCTL, 8'h40);
    do_sleep(1'b1, '0);
    rd(OFS_CSTAT, d);
    chk(d, 8'h18);
    $display("test flags and no-op done");
    for (int g = 0; g < 2; g++) begin
      do_reset();
      lfsr = lfsr_next(lfsr);
      timer_src <= lfsr[1:0];
      conv_rc_sel <= lfsr[2];
      slow <= g[0];
      ev = '{core: 3'h0, pa: 8'h00, pb: g[0] ? 8'h08 : 8'h40};
      wr(OFS_PREQB, 8'h00);
      wr(OFS_PENB, 8'h48);
      wr(OFS_INTCTL, {g[0], 7'h40});
      do_sleep(1'b0, g[0] ? ev : '0);
      if (g == 0) begin
        rd(OFS_CSTAT, d);
        chk(d, 8'h10);
        chk({7'h0, timer_run_ff}, {7'h0, timer_src != T1_SRC_SYS});
        chk({7'h0, conv_run_ff}, {7'h0, conv_rc_sel});
        chk({7'h0, lf_osc_run_ff}, 8'h01);
        evt <= ev;
        @(posedge clk);
        evt <= '0;
      end
      wait_wake(40);
      d = 8'h00;
      repeat (12) begin
        @(posedge clk);
        if (vector_ff === 1'b1) d = 8'h01;
      end
      chk(d, {7'h0, g[0]});
      chk({7'h0, irq_req_ff}, {7'h0, g[0]});
      rd(OFS_CSTAT, d);
      chk(d, 8'h10);
      clr_wdt <= 1'b1;
      @(posedge clk);
      clr_wdt <= 1'b0;
      rd(OFS_CSTAT, d);
      chk(d, 8'h18);
    end
    $display("test interrupt wake done");
    for (int s = 0; s < 3; s++) begin
      do_reset();
      do_sleep(1'b0, '0);
      mrp_en <= (s == 0);
      bor_en <= (s == 1);
      {mrp_evt, bor_evt, por_evt} <= 3'b100 >> s;
      @(posedge clk);
      {mrp_evt, bor_evt, por_evt} <= 3'h0;
      @(posedge clk);
      chk({6'h0, dev_reset_ff, wake_ff}, 8'h02);
    end
    $display("test reset wake done");
    do_reset();
    lfsr = lfsr_next(lfsr);
    wdt_mode <= lfsr[0] ? WDT_ALWAYS : WDT_SOFT;
    soft_en <= 1'b1;
    do_sleep(1'b0, '0);
    wait_wake(80);
    wdt_mode <= 2'h0;
    chk({7'h0, wdt_reset_ff}, 8'h00);
    rd(OFS_CSTAT, d);
    chk(d, 8'h00);
    $display("test watchdog wake done");
    do_reset();
    wdt_mode <= WDT_NO_SLEEP;
    d = 8'h00;
    repeat (60) begin
      @(posedge clk);
      if (wdt_reset_ff === 1'b1) d = 8'h01;
    end
    chk(d, 8'h01);
    do_sleep(1'b0, '0);
    d = 8'h00;
    repeat (60) begin
      @(posedge clk);
      if (wake_ff !== 1'b0 || wdt_reset_ff !== 1'b0) d = 8'h01;
    end
    chk(d, 8'h00);
    $display("test watchdog off in sleep done");
    print_verdict();
  end
endmodule : sleep_wake_controller_tb
